//--- src/ssd_pkg.sv
`default_nettype none
package ssd_pkg;
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned BAUD_OVERSAMP = 16;

    // register byte offsets
    localparam logic [7:0] OFS_BAUD   = 8'h00;
    localparam logic [7:0] OFS_PARITY = 8'h04;
    localparam logic [7:0] OFS_ADDR   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CTRL   = 8'h10;

    // field layouts
    localparam int unsigned BAUD_W   = 3;
    localparam int unsigned PARITY_W = 2;
    localparam int unsigned SADDR_W  = 8;
    localparam int unsigned ST_DEF_BIT    = 0;
    localparam int unsigned ST_RST_BIT    = 1;
    localparam int unsigned ST_BAUD_LSB   = 4;
    localparam int unsigned ST_PAR_LSB    = 8;
    localparam int unsigned ST_ADDR_LSB   = 16;
    localparam int unsigned CTRL_RELOAD_BIT = 0;

    // nonvolatile word indexes
    localparam logic [1:0] NV_IDX_BAUD   = 2'h0;
    localparam logic [1:0] NV_IDX_PARITY = 2'h1;
    localparam logic [1:0] NV_IDX_ADDR   = 2'h2;

    // parity codes
    localparam logic [PARITY_W-1:0] PAR_NONE = 2'h0;
    localparam logic [PARITY_W-1:0] PAR_EVEN = 2'h1;
    localparam logic [PARITY_W-1:0] PAR_ODD  = 2'h2;

    // baud codes: 0..7 = 1200,2400,4800,9600,19200,38400,57600,115200
    localparam logic [BAUD_W-1:0]  BAUD_9600   = 3'h3;
    localparam logic [SADDR_W-1:0] DEF_SADDR   = 8'h01;
    localparam logic [BAUD_W-1:0]  RST_BAUD    = BAUD_9600;
    localparam logic [PARITY_W-1:0] RST_PARITY = PAR_NONE;
    localparam logic [SADDR_W-1:0] RST_SADDR   = DEF_SADDR;

    // timing
    localparam int unsigned STRAP_FILT_US  = 10;
    localparam int unsigned STRAP_FILT_CYC =
        (STRAP_FILT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned INT_RST_NS     = 64;
    localparam int unsigned INT_RST_CYC    =
        (INT_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned DIV_W = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [DIV_W-1:0] baud_div(
        input logic [BAUD_W-1:0] code
    );
        int unsigned baud;
        baud = 1200 << code;
        if (code == 3'h6) begin
            baud = 57600;
        end
        if (code == 3'h7) begin
            baud = 115200;
        end
        baud_div = DIV_W'((CLK_HZ + (BAUD_OVERSAMP * baud) / 2)
                          / (BAUD_OVERSAMP * baud));
    endfunction : baud_div
endpackage : ssd_pkg
`default_nettype wire

//--- src/ssd_strap_filter.sv
`default_nettype none
module ssd_strap_filter #(
    parameter int unsigned FILT_CYC = 2500
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic strap_n,
    output logic      strap_on,
    output logic      strap_release
);
    logic       sync1_q;
    logic       sync2_q;
    logic [31:0] cnt_q;
    logic       on_q;
    logic       rel_q;
    wire logic  raw_on   = ~sync2_q;
    wire logic  differs  = (raw_on != on_q);
    wire logic  settled  = (cnt_q >= FILT_CYC - 1);

    generate
        if (FILT_CYC < 1) begin : g_chk
            $error("ssd_strap_filter: FILT_CYC must be at least 1");
        end
    endgenerate

    // pin sampled through two flops, first flop read by the second only
    always_ff @(posedge sys_clk) begin
        sync1_q <= strap_n;
        sync2_q <= sync1_q;
    end

    // level must hold unbroken for the whole window before it is taken
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cnt_q <= 32'h0;
            on_q  <= 1'b0;
            rel_q <= 1'b0;
        end else begin
            rel_q <= 1'b0;
            if (!differs) begin
                cnt_q <= 32'h0;
            end else if (settled) begin
                cnt_q <= 32'h0;
                on_q  <= raw_on;
                rel_q <= on_q;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end

    assign strap_on      = on_q;
    assign strap_release = rel_q;
endmodule : ssd_strap_filter
`default_nettype wire

//--- src/ssd_baud_gen.sv
`default_nettype none
module ssd_baud_gen #(
    parameter int unsigned DIV_W = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             clear,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);
    logic [DIV_W-1:0] cnt_q;
    logic             tick_q;
    wire logic        wrap = (cnt_q + DIV_W'(1) >= divisor);

    always_ff @(posedge sys_clk) begin
        if (!reset_n || clear) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= wrap;
            cnt_q  <= wrap ? '0 : cnt_q + DIV_W'(1);
        end
    end

    assign tick = tick_q;
endmodule : ssd_baud_gen
`default_nettype wire

//--- src/ssd_setup_top.sv
// Contract
// - setup values live in nonvolatile storage and are reloaded from it.
// - every setup value (baud, parity, address) is writable over the port.
// - a grounded default strap puts the block in the fixed default state.
// - default state runs the port at 9600 baud, 8 data, 1 stop, no parity.
// - default state answers only slave address 01, not the stored one.
// - the strap never changes stored values, only the ones in effect.
// - stored values stay readable at all times, default state included.
// - setup writes are accepted at any time, default state included.
// - stored baud/parity writes do not disturb the default 9600 8N1.
// - strap release triggers an internal reset, then stored baud/parity.
// - setup reads and writes travel as Modbus RTU over the serial link; here they go over the AXI4-Lite register port.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module ssd_setup_top #(
    parameter int unsigned ADDR_W   = 8,
    parameter int unsigned FILT_CYC = ssd_pkg::STRAP_FILT_CYC
) (
    input  wire logic                           sys_clk,
    input  wire logic                           reset_n,
    input  wire logic                           default_strap_n,

    input  wire logic [ADDR_W-1:0]              s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,

    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,

    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,

    input  wire logic [ADDR_W-1:0]              s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,

    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,

    input  wire logic [ssd_pkg::BAUD_W-1:0]     nv_rd_baud,
    input  wire logic [ssd_pkg::PARITY_W-1:0]   nv_rd_parity,
    input  wire logic [ssd_pkg::SADDR_W-1:0]    nv_rd_addr,

    output logic                                nv_wr_en,
    output logic [1:0]                          nv_wr_index,
    output logic [7:0]                          nv_wr_data,

    output logic                                default_active,
    output logic                                link_reset,
    output logic                                baud_tick,

    output logic [ssd_pkg::BAUD_W-1:0]          eff_baud_code,
    output logic [ssd_pkg::PARITY_W-1:0]        eff_parity,
    output logic [ssd_pkg::SADDR_W-1:0]         eff_slave_addr
);
    localparam int unsigned BW = ssd_pkg::BAUD_W;
    localparam int unsigned PW = ssd_pkg::PARITY_W;
    localparam int unsigned SW = ssd_pkg::SADDR_W;
    localparam int unsigned RW = 8;

    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
            $error("ssd_setup_top: ADDR_W must be 8..32");
        end
    endgenerate

    function automatic logic [7:0] reg_ofs(input logic [ADDR_W-1:0] a);
        reg_ofs = {a[7:2], 2'h0};
    endfunction : reg_ofs

    // offsets are contiguous words up to the control register
    function automatic logic reg_hit(input logic [7:0] ofs);
        reg_hit = (ofs <= ssd_pkg::OFS_CTRL);
    endfunction : reg_hit

    // strap conditioning
    logic strap_on;
    logic strap_release;

    ssd_strap_filter #(
        .FILT_CYC (FILT_CYC)
    ) u_filter (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .strap_n       (default_strap_n),
        .strap_on      (strap_on),
        .strap_release (strap_release)
    );

    // stored setup values
    logic [BW-1:0] st_baud_q;
    logic [PW-1:0] st_parity_q;
    logic [SW-1:0] st_addr_q;
    logic          nv_load_q;
    logic          nv_pend_q;

    // internal reset
    logic [RW-1:0] irst_cnt_q;
    logic          irst_q;

    // effective settings
    logic [BW-1:0] eff_baud_q;
    logic [PW-1:0] eff_par_q;
    logic [SW-1:0] eff_addr_q;
    logic          def_q;

    // write channel
    logic              aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;

    logic              w_held_q;
    logic [31:0]       w_data_q;
    logic              w_strb0_q;

    logic              bvalid_q;
    logic [1:0]        bresp_q;

    // read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // nonvolatile write port
    logic       nv_wr_q;
    logic [1:0] nv_idx_q;
    logic [7:0] nv_data_q;

    // write decode
    wire logic [7:0] wr_ofs   = reg_ofs(aw_addr_q);
    wire logic       wr_go    = aw_held_q && w_held_q && !bvalid_q;
    wire logic       wr_baud  = wr_ofs == ssd_pkg::OFS_BAUD;
    wire logic       wr_par   = wr_ofs == ssd_pkg::OFS_PARITY;
    wire logic       wr_addr  = wr_ofs == ssd_pkg::OFS_ADDR;
    wire logic       wr_ctrl  = wr_ofs == ssd_pkg::OFS_CTRL;
    wire logic       wr_hit   = reg_hit(wr_ofs);
    // lane 0 carries every field, so without it nothing is stored
    wire logic       wr_lane  = wr_go && w_strb0_q;
    wire logic       reload   = wr_lane && wr_ctrl
                                && w_data_q[ssd_pkg::CTRL_RELOAD_BIT];

    // read decode
    wire logic [7:0] rd_ofs   = reg_ofs(s_axi_araddr);
    wire logic       rd_take  = s_axi_arvalid && !rvalid_q;
    // status shows what the port really uses, not what is stored
    wire logic [31:0] status_word =
        (32'(def_q)      << ssd_pkg::ST_DEF_BIT)
      | (32'(irst_q)     << ssd_pkg::ST_RST_BIT)
      | (32'(eff_baud_q) << ssd_pkg::ST_BAUD_LSB)
      | (32'(eff_par_q)  << ssd_pkg::ST_PAR_LSB)
      | (32'(eff_addr_q) << ssd_pkg::ST_ADDR_LSB);
    wire logic [31:0] rd_mux =
        (rd_ofs == ssd_pkg::OFS_BAUD)   ? 32'(st_baud_q)   :
        (rd_ofs == ssd_pkg::OFS_PARITY) ? 32'(st_parity_q) :
        (rd_ofs == ssd_pkg::OFS_ADDR)   ? 32'(st_addr_q)   :
        (rd_ofs == ssd_pkg::OFS_STATUS) ? status_word      : 32'h0;
    wire logic rd_hit = reg_hit(rd_ofs);

    // stored baud, parity and address ignored here while the strap is on
    wire logic [BW-1:0] sel_baud =
        strap_on ? ssd_pkg::BAUD_9600 : st_baud_q;
    wire logic [PW-1:0] sel_par  =
        strap_on ? ssd_pkg::PAR_NONE : st_parity_q;
    wire logic [SW-1:0] sel_addr =
        strap_on ? ssd_pkg::DEF_SADDR : st_addr_q;

    // setup access path
    // AXI write address and data, taken in either order
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0;
            w_strb0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end

            if (s_axi_wvalid && !w_held_q) begin
                w_held_q  <= 1'b1;
                w_data_q  <= s_axi_wdata;
                w_strb0_q <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ssd_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? ssd_pkg::RESP_OKAY : ssd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= ssd_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? ssd_pkg::RESP_OKAY : ssd_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // reload from storage one cycle after reset release or on request
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            nv_pend_q <= 1'b1;
            nv_load_q <= 1'b0;
        end else begin
            nv_load_q <= nv_pend_q || reload;
            nv_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_baud_q   <= ssd_pkg::RST_BAUD;
            st_parity_q <= ssd_pkg::RST_PARITY;
            st_addr_q   <= ssd_pkg::RST_SADDR;
        end else if (nv_load_q) begin
            st_baud_q   <= nv_rd_baud;
            st_parity_q <= nv_rd_parity;
            st_addr_q   <= nv_rd_addr;
        end else if (wr_lane) begin
            if (wr_baud) begin
                st_baud_q <= w_data_q[BW-1:0];
            end
            if (wr_par) begin
                st_parity_q <= w_data_q[PW-1:0];
            end
            if (wr_addr) begin
                st_addr_q <= w_data_q[SW-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            nv_wr_q   <= 1'b0;
            nv_idx_q  <= ssd_pkg::NV_IDX_BAUD;
            nv_data_q <= 8'h00;
        end else begin
            nv_wr_q <= wr_lane && (wr_baud || wr_par || wr_addr);
            if (wr_lane) begin
                nv_idx_q  <= wr_par  ? ssd_pkg::NV_IDX_PARITY :
                             wr_addr ? ssd_pkg::NV_IDX_ADDR   :
                                       ssd_pkg::NV_IDX_BAUD;
                nv_data_q <= w_data_q[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irst_cnt_q <= '0;
            irst_q     <= 1'b0;
        end else if (strap_release) begin
            irst_cnt_q <= RW'(ssd_pkg::INT_RST_CYC);
            irst_q     <= 1'b1;
        end else if (irst_cnt_q != '0) begin
            irst_cnt_q <= irst_cnt_q - RW'(1);
            irst_q     <= (irst_cnt_q != RW'(1));
        end
    end

    // settings follow the selected ones except during internal reset or on strap release
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            eff_baud_q <= ssd_pkg::RST_BAUD;
            eff_par_q  <= ssd_pkg::RST_PARITY;
            eff_addr_q <= ssd_pkg::RST_SADDR;
            def_q      <= 1'b0;
        end else if (!irst_q && !strap_release) begin
            eff_baud_q <= sel_baud;
            eff_par_q  <= sel_par;
            eff_addr_q <= sel_addr;
            def_q      <= strap_on;
        end
    end

    // restart the bit clock whenever the rate may have changed
    wire logic baud_clear = irst_q || (eff_baud_q != sel_baud);

    // bit-rate enable follows only the settings in effect
    ssd_baud_gen #(
        .DIV_W (ssd_pkg::DIV_W)
    ) u_baud (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clear   (baud_clear),
        .divisor (ssd_pkg::baud_div(eff_baud_q)),
        .tick    (baud_tick)
    );

    assign s_axi_awready  = !aw_held_q;
    assign s_axi_wready   = !w_held_q;
    assign s_axi_bvalid   = bvalid_q;
    assign s_axi_bresp    = bresp_q;

    assign s_axi_arready  = !rvalid_q;
    assign s_axi_rvalid   = rvalid_q;
    assign s_axi_rdata    = rdata_q;
    assign s_axi_rresp    = rresp_q;

    assign nv_wr_en       = nv_wr_q;
    assign nv_wr_index    = nv_idx_q;
    assign nv_wr_data     = nv_data_q;

    assign default_active = def_q;
    assign link_reset     = irst_q;
    assign eff_baud_code  = eff_baud_q;
    assign eff_parity     = eff_par_q;
    assign eff_slave_addr = eff_addr_q;
endmodule : ssd_setup_top
`default_nettype wire

//--- verification/ssd_setup_props.sv
`default_nettype none
module ssd_setup_props #(
    parameter int unsigned FILT_CYC = 4
) (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       default_strap_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       nv_wr_en,
    input wire logic       default_active,
    input wire logic       link_reset,
    input wire logic [2:0] eff_baud_code,
    input wire logic [1:0] eff_parity,
    input wire logic [7:0] eff_slave_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] lo_q;
    logic [15:0] lo_d;
    logic [15:0] hi_q;
    logic [15:0] hi_d;
    logic [7:0]  rl_q;

    // raw pin run lengths, saturating
    assign lo_d = default_strap_n ? 16'h0000
                : lo_q + {15'h0000, lo_q != 16'hFFFF};
    assign hi_d = !default_strap_n ? 16'h0000
                : hi_q + {15'h0000, hi_q != 16'hFFFF};

    always_ff @(posedge sys_clk) begin
        lo_q <= reset_n ? lo_d : 16'h0000;
        hi_q <= reset_n ? hi_d : 16'h0000;
        rl_q <= (reset_n && link_reset) ? rl_q + 8'h01 : 8'h00;
    end

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    default_eff_a: assert property (
        default_active |-> eff_baud_code == ssd_pkg::BAUD_9600
            && eff_parity == ssd_pkg::PAR_NONE
            && eff_slave_addr == ssd_pkg::DEF_SADDR)
        else $error("default eff");
    strap_enter_a: assert property (
        lo_q >= FILT_CYC + 8 && !link_reset |-> default_active)
        else $error("strap enter");
    strap_filter_a: assert property (
        $rose(default_active) |-> lo_q >= FILT_CYC)
        else $error("strap glitch");
    release_rst_a: assert property (
        $rose(link_reset) |-> hi_q >= FILT_CYC)
        else $error("early reset");
    rst_length_a: assert property (
        $fell(link_reset) |-> rl_q == 8'(ssd_pkg::INT_RST_CYC))
        else $error("reset length");
    eff_hold_a: assert property (
        link_reset && $past(link_reset) |-> $stable(eff_baud_code)
            && $stable(eff_parity) && $stable(eff_slave_addr))
        else $error("eff moved");
    wr_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid)
        else $error("bvalid late");
    bresp_done_a: assert property (
        s_axi_bvalid && s_axi_bready && !s_axi_awvalid |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
    rdata_done_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    nv_cause_a: assert property (
        nv_wr_en |-> s_axi_bvalid || $past(s_axi_bvalid)
            || $past(s_axi_bvalid, 2))
        else $error("nv write");
endmodule : ssd_setup_props
`default_nettype wire

//--- verification/ssd_nv_model.sv
`default_nettype none
module ssd_nv_model #(
    parameter logic [7:0] INIT_BAUD   = 8'h05,
    parameter logic [7:0] INIT_PARITY = 8'h02,
    parameter logic [7:0] INIT_ADDR   = 8'h2A
) (
    input  wire logic       sys_clk,
    input  wire logic       nv_wr_en,
    input  wire logic [1:0] nv_wr_index,
    input  wire logic [7:0] nv_wr_data,
    output logic      [2:0] nv_rd_baud,
    output logic      [1:0] nv_rd_parity,
    output logic      [7:0] nv_rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem_q [3] = '{INIT_BAUD, INIT_PARITY, INIT_ADDR};

    // no reset here: words outlive every system reset
    always @(posedge sys_clk) begin
        if (nv_wr_en && nv_wr_index != 2'h3) begin
            mem_q[nv_wr_index] <= nv_wr_data;
        end
    end

    assign nv_rd_baud   = mem_q[ssd_pkg::NV_IDX_BAUD][2:0];
    assign nv_rd_parity = mem_q[ssd_pkg::NV_IDX_PARITY][1:0];
    assign nv_rd_addr   = mem_q[ssd_pkg::NV_IDX_ADDR];
endmodule : ssd_nv_model
`default_nettype wire

//--- verification/tb_ssd_setup_top.sv
`default_nettype none
module tb_ssd_setup_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FILT = 4;
    localparam logic [1:0] OK = ssd_pkg::RESP_OKAY;
    localparam logic [1:0] ER = ssd_pkg::RESP_SLVERR;
    localparam int unsigned TICK_GAP = (ssd_pkg::CLK_HZ
        + ssd_pkg::BAUD_OVERSAMP * 9600 / 2) / (ssd_pkg::BAUD_OVERSAMP * 9600);
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [1:0]  r;
    } ssd_row_t;
    logic        sys_clk, reset_n, default_strap_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, nv_wr_data, nv_rd_addr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, nv_wr_index, nv_rd_parity;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, nv_wr_en, default_active;
    logic        link_reset, baud_tick;
    logic [2:0]  nv_rd_baud, eff_baud_code;
    logic [1:0]  eff_parity;
    logic [7:0]  eff_slave_addr;
    int          error_cnt = 0;
    int          n_tests = 0;
    ssd_row_t    rows [13] = '{
        '{1'b0, 8'h00, 32'h5, 4'h0, OK},
        '{1'b0, 8'h04, 32'h2, 4'h0, OK},
        '{1'b0, 8'h08, 32'h2A, 4'h0, OK},
        '{1'b1, 8'h00, 32'h6, 4'hF, OK},
        '{1'b1, 8'h04, 32'h1, 4'hF, OK},
        '{1'b1, 8'h08, 32'h37, 4'hF, OK},
        '{1'b1, 8'h08, 32'h55, 4'hE, OK},
        '{1'b0, 8'h08, 32'h37, 4'h0, OK},
        '{1'b0, 8'h00, 32'h6, 4'h0, OK},
        '{1'b0, 8'h0C, 32'h370160, 4'h0, OK},
        '{1'b0, 8'h10, 32'h0, 4'h0, OK},
        '{1'b0, 8'h14, 32'h0, 4'h0, ER},
        '{1'b1, 8'h14, 32'h1, 4'hF, ER}
    };

    ssd_setup_top #(.FILT_CYC(FILT)) u_ssd_setup_top (.*);
    ssd_nv_model u_ssd_nv_model (.*);

    function automatic logic [31:0] eff_now();
        return 32'({eff_baud_code, eff_parity, eff_slave_addr});
    endfunction : eff_now

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        logic pa = 1'b1;
        logic pw = 1'b1;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // either channel may be taken first
        while (pa || pw) begin
            @(posedge sys_clk);
            pa = pa && s_axi_awready !== 1'b1;
            pw = pw && s_axi_wready !== 1'b1;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (10000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        int n;
        reset_n = 1'b0;
        default_strap_n = 1'b1;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_wr(rows[i].a, rows[i].d, rows[i].s, rsp);
            end else begin
                axi_rd(rows[i].a, rd, rsp);
                chk("rdata", rows[i].d, rd);
            end
            chk("resp", 32'(rows[i].r), 32'(rsp));
        end
        repeat (4) @(posedge sys_clk);
        chk("nv", 32'({3'h6, 2'h1, 8'h37}),
            32'({nv_rd_baud, nv_rd_parity, nv_rd_addr}));
        reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        chk("eff in reset", 32'({3'h3, 2'h0, 8'h01}), eff_now());
        @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("eff reload", 32'({3'h6, 2'h1, 8'h37}), eff_now());
        @(posedge sys_clk);
        default_strap_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        default_strap_n <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chk("glitch", 32'h0, 32'(default_active));
        default_strap_n <= 1'b0;
        for (n = 0; n < 60 && default_active !== 1'b1; n++) begin
            @(posedge sys_clk);
        end
        #1;
        chk("default on", 32'h1, 32'(default_active));
        chk("eff dflt", 32'({ssd_pkg::BAUD_9600, ssd_pkg::PAR_NONE,
            ssd_pkg::DEF_SADDR}), eff_now());
        axi_rd(8'h08, rd, rsp);
        chk("stored addr", 32'h37, rd);
        axi_wr(8'h00, 32'h7, 4'hF, rsp);
        chk("wr resp", 32'(OK), 32'(rsp));
        axi_wr(8'h04, 32'(ssd_pkg::PAR_ODD), 4'hF, rsp);
        axi_rd(8'h00, rd, rsp);
        chk("stored baud", 32'h7, rd);
        @(posedge sys_clk iff baud_tick === 1'b1);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (baud_tick !== 1'b1 && n < 4000);
        chk("tick gap", TICK_GAP, 32'(n));
        chk("eff kept", 32'({3'h3, 2'h0, 8'h01}), eff_now());
        @(posedge sys_clk);
        default_strap_n <= 1'b1;
        for (n = 0; n < 60 && link_reset !== 1'b1; n++) begin
            @(posedge sys_clk);
        end
        chk("link reset", 32'h1, 32'(link_reset));
        for (n = 0; n < 40 && link_reset === 1'b1; n++) begin
            @(posedge sys_clk);
        end
        chk("reset len", 32'h10, 32'(n));
        repeat (2) @(posedge sys_clk);
        #1;
        chk("default off", 32'h0, 32'(default_active));
        chk("eff stored", 32'({3'h7, ssd_pkg::PAR_ODD, 8'h37}),
            eff_now());
        report_and_stop();
    end
endmodule : tb_ssd_setup_top

bind ssd_setup_top ssd_setup_props #(.FILT_CYC(FILT_CYC))
    u_ssd_setup_props (.*);
`default_nettype wire
